// ### hw/ext_bus_pkg.sv
package ext_bus_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] TIMING_INDEX = 8'haa;
   localparam logic [7:0] CONFIG_INDEX = 8'hab;
   localparam logic [7:0] BANK_INDEX = 8'hac;
   localparam logic [7:0] STATUS_INDEX = 8'had;
   localparam logic [11:0] TIMING_ADDR = {2'h0, TIMING_INDEX, 2'h0};
   localparam logic [11:0] CONFIG_ADDR = {2'h0, CONFIG_INDEX, 2'h0};
   localparam logic [11:0] BANK_ADDR = {2'h0, BANK_INDEX, 2'h0};
   localparam logic [11:0] STATUS_ADDR = {2'h0, STATUS_INDEX, 2'h0};
   // reset values
   localparam logic [7:0] TIMING_RESET = 8'hff;
   localparam logic [4:0] CONFIG_RESET = 5'h00;
   localparam logic [7:0] BANK_RESET = 8'h00;
   // timing register fields
   localparam int SETUP_LSB = 6;
   localparam int WIDTH_LSB = 2;
   localparam int HOLD_LSB = 0;
   // config register fields: mode code 4:2, latch width 1:0
   localparam int MODE_LSB = 2;
   localparam int MUX_SELECT_BIT = 4;
   localparam int LATCH_LSB = 0;
   localparam logic [2:0] MODE_MUX_BANK = 3'h2;
   localparam logic [2:0] MODE_DEMUX_BANK = 3'h6;
   // fixed overhead: one start cycle plus tail
   localparam logic [3:0] TAIL_CYCLES = 4'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_ALE_HI = 3'b010,
      ST_ALE_LO = 3'b011,
      ST_SETUP = 3'b100,
      ST_STROBE = 3'b101,
      ST_HOLD = 3'b110,
      ST_TAIL = 3'b111
   } state_t;
endpackage

// ### hw/external_memory_bus_timing.sv
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
module external_memory_bus_timing (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // external data move request from the processor
   input wire logic move_req,
   input wire logic move_write,
   input wire logic move_8bit,
   input wire logic [15:0] move_addr,
   input wire logic [7:0] move_wdata,
   output logic move_busy,
   output logic move_done,
   output logic [7:0] move_rdata,
   // memory pins
   output logic [7:0] addr_hi_o,
   output logic addr_hi_oe,
   output logic [7:0] addr_lo_o,
   output logic addr_lo_oe,
   input wire logic [7:0] ad_i,
   output logic [7:0] ad_o,
   output logic ad_oe,
   output logic latch_strobe,
   output logic rd_strobe_n,
   output logic wr_strobe_n
);
   typedef struct packed {
      ext_bus_pkg::state_t st;
      logic [3:0] cnt;
      logic [7:0] timing;
      logic [4:0] config_bits;
      logic [7:0] bank;
      logic is_wr;
      logic is_mux;
      logic drive_hi;
      logic [15:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic [7:0] sync0;
      logic [7:0] sync1;
      logic rd_mark0;
      logic rd_mark1;
      logic busy;
      logic done;
      logic [7:0] addr_hi;
      logic addr_hi_oe;
      logic [7:0] addr_lo;
      logic addr_lo_oe;
      logic [7:0] ad;
      logic ad_oe;
      logic ale;
      logic rd_n;
      logic wr_n;
      logic awready;
      logic wready;
      logic aw_have;
      logic w_have;
      logic [11:0] waddr;
      logic [7:0] wreg;
      logic wreg_en;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata_bus;
      logic [1:0] rresp;
   } state_s_t;

   state_s_t s_q;
   state_s_t s_d;

   logic [1:0] setup_f;
   logic [3:0] width_f;
   logic [1:0] hold_f;
   logic [1:0] latch_f;

   assign setup_f = s_q.timing[ext_bus_pkg::SETUP_LSB +: 2];
   assign width_f = s_q.timing[ext_bus_pkg::WIDTH_LSB +: 4];
   assign hold_f = s_q.timing[ext_bus_pkg::HOLD_LSB +: 2];
   assign latch_f = s_q.config_bits[ext_bus_pkg::LATCH_LSB +: 2];

   always_comb begin
      logic last;
      logic [2:0] mode;
      logic drive_addr;
      logic [31:0] rd_word;
      logic rd_ok;
      last = (s_q.cnt == 4'h0);
      mode = s_q.config_bits[ext_bus_pkg::MODE_LSB +: 3];
      drive_addr = 1'b0;
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      s_d = s_q;
      s_d.done = 1'b0;

      // sequencer
      case (s_q.st)
         ext_bus_pkg::ST_IDLE: begin
            if (move_req) begin
               s_d.st = ext_bus_pkg::ST_START;
               s_d.is_wr = move_write;
               s_d.addr = move_addr;
               s_d.wdata = move_wdata;
               s_d.is_mux = ~mode[ext_bus_pkg::MUX_SELECT_BIT - ext_bus_pkg::MODE_LSB];
               // 8-bit accesses drive the high byte only with bank select
               s_d.drive_hi = ~move_8bit || mode == ext_bus_pkg::MODE_MUX_BANK
                  || mode == ext_bus_pkg::MODE_DEMUX_BANK;
               if (move_8bit) begin
                  s_d.addr[15:8] = s_q.bank;
               end
               s_d.busy = 1'b1;
            end
         end
         ext_bus_pkg::ST_START: begin
            if (s_q.is_mux) begin
               s_d.st = ext_bus_pkg::ST_ALE_HI;
               s_d.cnt = {2'h0, latch_f};
            end else if (setup_f != 2'h0) begin
               s_d.st = ext_bus_pkg::ST_SETUP;
               s_d.cnt = {2'h0, setup_f - 2'h1};
            end else begin
               s_d.st = ext_bus_pkg::ST_STROBE;
               s_d.cnt = width_f;
            end
         end
         ext_bus_pkg::ST_ALE_HI: begin
            s_d.cnt = s_q.cnt - 4'h1;
            if (last) begin
               s_d.st = ext_bus_pkg::ST_ALE_LO;
               s_d.cnt = {2'h0, latch_f};
            end
         end
         ext_bus_pkg::ST_ALE_LO, ext_bus_pkg::ST_SETUP: begin
            s_d.cnt = s_q.cnt - 4'h1;
            if (last) begin
               if (s_q.st == ext_bus_pkg::ST_ALE_LO && setup_f != 2'h0) begin
                  s_d.st = ext_bus_pkg::ST_SETUP;
                  s_d.cnt = {2'h0, setup_f - 2'h1};
               end else begin
                  s_d.st = ext_bus_pkg::ST_STROBE;
                  s_d.cnt = width_f;
               end
            end
         end
         ext_bus_pkg::ST_STROBE: begin
            s_d.cnt = s_q.cnt - 4'h1;
            if (last) begin
               if (hold_f != 2'h0) begin
                  s_d.st = ext_bus_pkg::ST_HOLD;
                  s_d.cnt = {2'h0, hold_f - 2'h1};
               end else begin
                  s_d.st = ext_bus_pkg::ST_TAIL;
                  s_d.cnt = ext_bus_pkg::TAIL_CYCLES - 4'h1;
               end
            end
         end
         ext_bus_pkg::ST_HOLD: begin
            s_d.cnt = s_q.cnt - 4'h1;
            if (last) begin
               s_d.st = ext_bus_pkg::ST_TAIL;
               s_d.cnt = ext_bus_pkg::TAIL_CYCLES - 4'h1;
            end
         end
         ext_bus_pkg::ST_TAIL: begin
            s_d.cnt = s_q.cnt - 4'h1;
            if (last) begin
               // busy stays up through hold and tail, so no overlap
               s_d.st = ext_bus_pkg::ST_IDLE;
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
            end
         end
         default: begin
            s_d.st = ext_bus_pkg::ST_IDLE;
            s_d.busy = 1'b0;
         end
      endcase

      // pins follow the next state so they leave flip-flops aligned with it
      drive_addr = s_d.st inside {ext_bus_pkg::ST_START, ext_bus_pkg::ST_ALE_HI, ext_bus_pkg::ST_ALE_LO,
         ext_bus_pkg::ST_SETUP, ext_bus_pkg::ST_STROBE, ext_bus_pkg::ST_HOLD};
      s_d.addr_hi = s_d.addr[15:8];
      s_d.addr_hi_oe = drive_addr && s_d.drive_hi;
      s_d.addr_lo = s_d.addr[7:0];
      s_d.addr_lo_oe = drive_addr && !s_d.is_mux;
      s_d.ale = s_d.st == ext_bus_pkg::ST_ALE_HI;
      s_d.rd_n = !(s_d.st == ext_bus_pkg::ST_STROBE && !s_d.is_wr);
      s_d.wr_n = !(s_d.st == ext_bus_pkg::ST_STROBE && s_d.is_wr);
      if (s_d.st == ext_bus_pkg::ST_ALE_HI) begin
         s_d.ad = s_d.addr[7:0];
         s_d.ad_oe = 1'b1;
      end else begin
         s_d.ad = s_d.wdata;
         // data from setup through hold, never during the latch phase
         s_d.ad_oe = s_d.is_wr && s_d.st inside {ext_bus_pkg::ST_SETUP, ext_bus_pkg::ST_STROBE,
            ext_bus_pkg::ST_HOLD};
      end

      // read data through two flops; mark tracks the sample taken on the last strobe edge
      s_d.sync0 = ad_i;
      s_d.sync1 = s_q.sync0;
      s_d.rd_mark0 = s_q.st == ext_bus_pkg::ST_STROBE && last && !s_q.is_wr;
      s_d.rd_mark1 = s_q.rd_mark0;
      if (s_q.rd_mark1) begin
         s_d.rdata = s_q.sync1;
      end

      // axi write channels, address and data in either order
      if (s_axi_awvalid && s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.wreg = s_axi_wdata[7:0];
         s_d.wreg_en = s_axi_wstrb[0];
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.aw_have && s_q.w_have) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = ext_bus_pkg::RESP_OKAY;
         case (s_q.waddr)
            ext_bus_pkg::TIMING_ADDR: if (s_q.wreg_en) s_d.timing = s_q.wreg;
            ext_bus_pkg::CONFIG_ADDR: if (s_q.wreg_en) s_d.config_bits = s_q.wreg[4:0];
            ext_bus_pkg::BANK_ADDR: if (s_q.wreg_en) s_d.bank = s_q.wreg;
            ext_bus_pkg::STATUS_ADDR: s_d.bresp = ext_bus_pkg::RESP_OKAY;
            default: s_d.bresp = ext_bus_pkg::RESP_SLVERR;
         endcase
      end
      s_d.awready = !s_d.aw_have && !s_d.bvalid;
      s_d.wready = !s_d.w_have && !s_d.bvalid;

      // axi read
      case (s_axi_araddr)
         ext_bus_pkg::TIMING_ADDR: rd_word = {24'h0, s_q.timing};
         ext_bus_pkg::CONFIG_ADDR: rd_word = {27'h0, s_q.config_bits};
         ext_bus_pkg::BANK_ADDR: rd_word = {24'h0, s_q.bank};
         ext_bus_pkg::STATUS_ADDR: rd_word = {20'h0, 1'b0, s_q.st, s_q.rdata};
         default: rd_ok = 1'b0;
      endcase
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rdata_bus = rd_word;
         s_d.rresp = rd_ok ? ext_bus_pkg::RESP_OKAY : ext_bus_pkg::RESP_SLVERR;
      end
      s_d.arready = !s_d.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.st <= ext_bus_pkg::ST_IDLE;
         s_q.timing <= ext_bus_pkg::TIMING_RESET;
         s_q.config_bits <= ext_bus_pkg::CONFIG_RESET;
         s_q.bank <= ext_bus_pkg::BANK_RESET;
         s_q.rd_n <= 1'b1;
         s_q.wr_n <= 1'b1;
         s_q.awready <= 1'b1;
         s_q.wready <= 1'b1;
         s_q.arready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready = s_q.awready;
   assign s_axi_wready = s_q.wready;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata_bus;
   assign s_axi_rresp = s_q.rresp;
   assign move_busy = s_q.busy;
   assign move_done = s_q.done;
   assign move_rdata = s_q.rdata;
   assign addr_hi_o = s_q.addr_hi;
   assign addr_hi_oe = s_q.addr_hi_oe;
   assign addr_lo_o = s_q.addr_lo;
   assign addr_lo_oe = s_q.addr_lo_oe;
   assign ad_o = s_q.ad;
   assign ad_oe = s_q.ad_oe;
   assign latch_strobe = s_q.ale;
   assign rd_strobe_n = s_q.rd_n;
   assign wr_strobe_n = s_q.wr_n;
endmodule // external_memory_bus_timing

// ### dv/ext_mem_model.sv
`timescale 1ns/10ps
module ext_mem_model (
   // clock and mode
   input wire logic aclk,
   input wire logic mux,
   // pins from the interface
   input wire logic [7:0] addr_lo_o,
   input wire logic [7:0] ad_o,
   input wire logic ad_oe,
   input wire logic latch_strobe,
   input wire logic rd_strobe_n,
   input wire logic wr_strobe_n,
   // shared pins back
   output logic [7:0] ad_i
);
   logic [7:0] mem [256];
   logic [7:0] lat_q;
   logic [7:0] last_q = 8'h00;
   logic [7:0] a;
   initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
   // follows the pins while high, frozen once it falls; edge-sampled so the
   // data that replaces the address at the fall cannot race into the latch
   always @(posedge aclk) if (latch_strobe) lat_q <= ad_o;
   assign a = mux ? lat_q : addr_lo_o;
   always @(posedge aclk) if (!wr_strobe_n && ad_oe) mem[a] <= ad_o;
   // unknown pins before reset would otherwise stick in the toggle forever
   always @(posedge aclk) if (!$isunknown(ad_i)) last_q <= ad_i;
   // data only inside the strobe; released pins toggle so no stale byte is seen
   assign ad_i = ad_oe ? ad_o : (!rd_strobe_n ? mem[a] : ~last_q);
endmodule // ext_mem_model

// ### dv/ext_bus_props.sv
`timescale 1ns/10ps
module ext_bus_props (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // watched ports
   input wire logic move_req,
   input wire logic move_busy,
   input wire logic move_done,
   input wire logic ad_oe,
   input wire logic latch_strobe,
   input wire logic rd_strobe_n,
   input wire logic wr_strobe_n
);
   wire logic strb_n = rd_strobe_n & wr_strobe_n;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   strobe_excl_a: assert property (rd_strobe_n || wr_strobe_n) else $error("both strobes low");
   idle_quiet_a: assert property (!move_busy |-> strb_n && !latch_strobe) else $error("pins active while idle");
   req_accept_a: assert property (move_req && !move_busy && !move_done |=> move_busy) else $error("request not taken");
   latch_high_a: assert property ($rose(latch_strobe) |-> ##[1:4] !latch_strobe) else $error("latch high too long");
   latch_low_a: assert property ($fell(latch_strobe) |-> ##[1:7] !strb_n) else $error("latch low phase too long");
   latch_addr_a: assert property (latch_strobe |-> ad_oe && strb_n) else $error("address not driven in latch");
   wr_data_a: assert property (!wr_strobe_n |-> ad_oe) else $error("write data missing");
   rd_float_a: assert property (!rd_strobe_n |-> !ad_oe) else $error("pins driven during read");
   strobe_width_a: assert property ($fell(strb_n) |-> ##[1:16] strb_n) else $error("strobe too long");
   data_hold_a: assert property ($rose(wr_strobe_n) |-> ##[0:3] !ad_oe) else $error("write data held too long");
   access_len_a: assert property ($rose(move_busy) |-> ##[3:40] move_done) else $error("access too long");
   done_pulse_a: assert property (move_done |-> !move_busy ##1 !move_done) else $error("done not a pulse");
   cover property ($rose(latch_strobe));
   cover property ($fell(rd_strobe_n));
   cover property ($fell(wr_strobe_n));
endmodule // ext_bus_props
bind external_memory_bus_timing ext_bus_props ext_bus_props_i (.aclk(aclk), .aresetn(aresetn),
   .move_req(move_req), .move_busy(move_busy), .move_done(move_done), .ad_oe(ad_oe),
   .latch_strobe(latch_strobe), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n));

// ### dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   localparam logic [1:0] OK = ext_bus_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = ext_bus_pkg::RESP_SLVERR;
   logic aclk = 1'b0, aresetn = 1'b0, mux = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic move_req = 1'b0, move_write = 1'b0, move_8bit = 1'b0;
   logic [15:0] move_addr = 16'h0;
   logic [7:0] move_wdata = 8'h0, move_rdata, addr_hi_o, addr_lo_o, ad_i, ad_o;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, move_busy, move_done;
   logic addr_hi_oe, addr_lo_oe, ad_oe, latch_strobe, rd_strobe_n, wr_strobe_n;
   logic [7:0] shadow [256];
   int errors = 0, n_compared = 0;
   always #5 aclk = ~aclk;
   external_memory_bus_timing external_memory_bus_timing_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .move_req, .move_write, .move_8bit, .move_addr, .move_wdata,
      .move_busy, .move_done, .move_rdata, .addr_hi_o, .addr_hi_oe, .addr_lo_o, .addr_lo_oe, .ad_i, .ad_o,
      .ad_oe, .latch_strobe, .rd_strobe_n, .wr_strobe_n);
   ext_mem_model ext_mem_model_i (.aclk, .mux, .addr_lo_o, .ad_o, .ad_oe, .latch_strobe, .rd_strobe_n,
      .wr_strobe_n, .ad_i);
   task automatic close_out();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1) begin
         errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic tmo(input int i);
      if (i >= 60) begin
         chk(1'b0, "timeout");
         close_out();
      end
   endtask
   function automatic int exp_len(logic [7:0] t, logic [4:0] c);
      return 1 + (c[4] ? 0 : 2 * (c[1:0] + 1)) + t[7:6] + t[5:2] + 1 + t[1:0] + 3;
   endfunction
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 60; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      tmo(i);
      chk(s_axi_bresp === r, "write response");
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 60; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      tmo(i);
      chk(s_axi_rdata === {24'h0, d} && s_axi_rresp === r, "read data");
   endtask
   task automatic mv(input logic w, b8, input logic [15:0] a, input logic [7:0] d, t, bk, input logic [4:0] c);
      int i, nl, ns;
      logic hoe, ok, loe;
      logic [7:0] hv, lv;
      nl = 0;
      ns = 0;
      ok = 1'b1;
      hoe = 1'b0;
      hv = 8'h0;
      loe = 1'b0;
      lv = 8'h0;
      @(posedge aclk);
      move_req <= 1'b1;
      move_write <= w;
      move_8bit <= b8;
      move_addr <= a;
      move_wdata <= d;
      @(posedge aclk);
      move_req <= 1'b0;
      for (i = 1; i < 60; i++) begin
         @(posedge aclk);
         #1;
         if (latch_strobe) begin
            nl++;
            ok &= (ad_o === a[7:0]);
         end
         if (!rd_strobe_n || !wr_strobe_n) begin
            ns++;
            hoe = addr_hi_oe;
            hv = addr_hi_o;
            loe = addr_lo_oe;
            lv = addr_lo_o;
         end
         if (move_done) break;
      end
      tmo(i);
      chk(i === exp_len(t, c), "access length");
      chk(ns === t[5:2] + 1, "strobe width");
      chk(nl === (c[4] ? 0 : c[1:0] + 1) && ok, "latch phase");
      chk(hoe === (!b8 || c[4:2] == 3'h2 || c[4:2] == 3'h6), "upper enable");
      if (hoe) chk(hv === (b8 ? bk : a[15:8]), "upper byte");
      chk(loe === c[4] && (!loe || lv === a[7:0]), "lower address");
      if (!w) chk(move_rdata === shadow[a[7:0]], "memory data");
      else shadow[a[7:0]] = d;
   endtask
   initial begin
      logic [7:0] t, bk, d;
      logic [4:0] c;
      logic [15:0] a;
      logic b8;
      void'($urandom(32'h7c0c6058));
      for (int i = 0; i < 256; i++) shadow[i] = i[7:0] ^ 8'h5a;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ext_bus_pkg::TIMING_ADDR, 8'hff, OK);
      rd(ext_bus_pkg::CONFIG_ADDR, 8'h00, OK);
      rd(12'h000, 8'h00, ERR);
      wr(12'h3fc, 8'h5a, ERR);
      for (int m = 1; m < 8; m++) begin
         for (int r = 0; r < 4 && m != 4; r++) begin
            t = (r == 0) ? 8'h00 : (r == 1) ? 8'hff : 8'($urandom());
            c = {m[2:0], 2'($urandom())};
            bk = 8'($urandom());
            a = 16'($urandom());
            d = 8'($urandom());
            b8 = r[0];
            wr(ext_bus_pkg::TIMING_ADDR, t, OK);
            wr(ext_bus_pkg::CONFIG_ADDR, {3'h0, c}, OK);
            wr(ext_bus_pkg::BANK_ADDR, bk, OK);
            rd(ext_bus_pkg::TIMING_ADDR, t, OK);
            mux <= !c[ext_bus_pkg::MUX_SELECT_BIT];
            mv(1'b0, !b8, a ^ 16'h0033, 8'h00, t, bk, c);
            mv(1'b1, b8, a, d, t, bk, c);
            mv(1'b0, b8, a, 8'h00, t, bk, c);
            rd(ext_bus_pkg::STATUS_ADDR, d, OK);
         end
      end
      // reset in mid-run must bring the timing back to its slowest setting
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ext_bus_pkg::TIMING_ADDR, 8'hff, OK);
      rd(ext_bus_pkg::BANK_ADDR, 8'h00, OK);
      close_out();
   end
endmodule // tb_top
